/* logic/ras_map.svh */
// Purpose: constants of the receiver audio serial output port
// Assumes: system clock is the master clock, 10 MHz
// Notes:   timing counts are in system clock cycles
// Functional notes
// [RULE1] as master, every output sample spans exactly 32 bit-clock periods.
// [RULE2] as slave, the far party supplies exactly 32 bit-clock periods per sample.
// [RULE3] master-select set drives bit clock and frame sync; clear takes them as inputs.
// [RULE4] edge-select set: data launched on falling edge, latched on rising.
// [RULE5] edge-select clear: data launched on rising edge, latched on falling.
// [RULE6] fixed formats 1, 3 and 9 are slave; all others are master.
// [RULE7] fixed formats 2, 3, 5, 6 and 7 launch on falling edge; others rising.
// [RULE8] rate report offers 88.2 kHz and 96 kHz ranges, no 400 ppm ranges.
// [RULE9] as master, bit clock is master clock divided by four.
`ifndef RAS_MAP_SVH
`define RAS_MAP_SVH

`define RAS_CLK_PERIOD_NS 100
`define RAS_MCK_DIV       4
`define RAS_SLOT_BITS     32
`define RAS_SAMPLE_W      24
`define RAS_FIFO_DEPTH    8
`define RAS_FMT_W         4
// frame-sync period windows, in system clocks
`define RAS_P96_LO        10'd100
`define RAS_P96_HI        10'd108
`define RAS_P882_LO       10'd109
`define RAS_P882_HI       10'd118
`define RAS_P48_LO        10'd200
`define RAS_P48_HI        10'd217
`define RAS_P441_LO       10'd218
`define RAS_P441_HI       10'd236
`define RAS_P32_LO        10'd300
`define RAS_P32_HI        10'd325
`define RAS_PERIOD_MAX    10'h3FF

`endif

/* logic/ras_pkg.sv */
// Purpose: types of the receiver audio serial output port
// Assumes: ras_map.svh holds the numbers
// Notes:   rate codes are the report seen on the rate output
package ras_pkg;
  typedef enum logic [2:0] {
    RAS_RATE_NONE = 3'h0,
    RAS_RATE_96   = 3'h1,
    RAS_RATE_882  = 3'h2,
    RAS_RATE_48   = 3'h3,
    RAS_RATE_441  = 3'h4,
    RAS_RATE_32   = 3'h5
  } ras_rate_e;
endpackage

/* logic/ras_fifo.sv */
// Purpose: sample buffer with registered read data
// Assumes: one clock, asynchronous active-low reset
// Notes:   first word falls through into the output register
`timescale 1ns/10ps
module ras_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        room;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } ras_fifo_s;

  ras_fifo_s st;
  ras_fifo_s next_st;
  logic      push;
  logic      pop;

  assign o_in_ready  = st.room;
  assign o_out_valid = st.out_valid;
  assign o_out_data  = st.out_data;

  always_comb begin
    next_st = st;
    push    = i_in_valid && st.room;
    pop     = (st.count != '0) && (!st.out_valid || i_out_ready);
    if (push) begin
      next_st.mem[st.wptr] = i_in_data;
      next_st.wptr         = st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.out_data = st.mem[st.rptr];
      next_st.rptr     = st.rptr + 1'b1;
    end
    if (pop) begin
      next_st.out_valid = 1'b1;
    end else if (i_out_ready) begin
      next_st.out_valid = 1'b0;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    // registered so the fill side sees back-pressure straight from a flop
    next_st.room  = next_st.count != (AW+1)'(DEPTH);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st      <= '0;
      st.room <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

/* logic/ras_serial_out.sv */
// Purpose: serial audio output port of a digital audio receiver
// Assumes: I_SYS_CLK is the master clock; slave bit clock below a quarter of it
// Notes:   one 24-bit sample per 32-bit slot, MSB first, zero padded
`timescale 1ns/10ps
`include "ras_map.svh"
module ras_serial_out (
  // clock and reset
  input  wire logic                         I_SYS_CLK,
  input  wire logic                         I_RST_N,
  // mode control
  input  wire logic                         I_MASTER_SELECT,
  input  wire logic                         I_CLOCK_EDGE_SELECT,
  input  wire logic                         I_FIXED_FORMAT_EN,
  input  wire logic [`RAS_FMT_W-1:0]        I_FORMAT,
  // recovered samples
  input  wire logic                         I_SAMPLE_VALID,
  input  wire logic [`RAS_SAMPLE_W-1:0]     I_SAMPLE_DATA,
  output logic                              O_SAMPLE_READY,
  // serial pins
  input  wire logic                         I_BIT_CLK,
  output logic                              O_BIT_CLK,
  output logic                              O_BIT_CLK_OE,
  input  wire logic                         I_FRAME_SYNC,
  output logic                              O_FRAME_SYNC,
  output logic                              O_FRAME_SYNC_OE,
  output logic                              O_SERIAL_AUDIO_OUT,
  // status
  output logic                              O_UNDERRUN,
  output ras_pkg::ras_rate_e                O_OUTPUT_WORD_RATE
);
  import ras_pkg::*;

  localparam int SW = `RAS_SAMPLE_W;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic               master_select;
    logic               clock_edge_select;
    logic [1:0]         div;
    logic               bclk;
    logic               fs;
    logic [1:0]         bclk_sync;
    logic [1:0]         fs_sync;
    logic               bclk_prev;
    logic               fs_last;
    logic [4:0]         bit_cnt;
    logic [31:0]        shift;
    logic               underrun;
    logic               fs_rise_prev;
    logic [9:0]         period;
    ras_rate_e          rate;
  } ras_state_s;

  ras_state_s            st;
  ras_state_s            next_st;
  logic                  fifo_valid;
  logic [SW-1:0]         fifo_data;
  logic                  fifo_take;
  logic                  fmt_slave;
  logic                  fmt_fall;
  logic                  rise;
  logic                  fall;
  logic                  launch;
  logic                  slot_start;
  logic                  fs_now;

  // ****************************************************************
  // sample buffer
  // ****************************************************************
  ras_fifo #(
    .WIDTH (SW),
    .DEPTH (`RAS_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_SYS_CLK),
    .i_rst_n     (I_RST_N),
    .i_in_valid  (I_SAMPLE_VALID),
    .i_in_data   (I_SAMPLE_DATA),
    .o_in_ready  (O_SAMPLE_READY),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_take)
  );

  assign O_BIT_CLK          = st.bclk;
  assign O_BIT_CLK_OE       = st.master_select;
  assign O_FRAME_SYNC       = st.fs;
  assign O_FRAME_SYNC_OE    = st.master_select;
  assign O_SERIAL_AUDIO_OUT = st.shift[31];
  assign O_UNDERRUN         = st.underrun;
  assign O_OUTPUT_WORD_RATE = st.rate;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    fmt_slave = (I_FORMAT == 4'h1) || (I_FORMAT == 4'h3) || (I_FORMAT == 4'h9);  // [RULE6]
    fmt_fall  = (I_FORMAT == 4'h2) || (I_FORMAT == 4'h3) || (I_FORMAT == 4'h5) ||
                (I_FORMAT == 4'h6) || (I_FORMAT == 4'h7);                       // [RULE7]
    next_st.master_select     = I_FIXED_FORMAT_EN ? !fmt_slave : I_MASTER_SELECT; // [RULE3]
    next_st.clock_edge_select = I_FIXED_FORMAT_EN ? fmt_fall : I_CLOCK_EDGE_SELECT;

    next_st.bclk_sync = {st.bclk_sync[0], I_BIT_CLK};
    next_st.fs_sync   = {st.fs_sync[0], I_FRAME_SYNC};
    next_st.bclk_prev = st.bclk_sync[1];

    // master bit clock: a 2-bit divider, high for two of four cycles
    next_st.div  = st.div + 2'h1;                                               // [RULE9]
    next_st.bclk = st.master_select && next_st.div[1];                          // [RULE9]
    if (st.master_select) begin
      rise = (st.div == 2'h1);
      fall = (st.div == 2'h3);
    end else begin
      // slave edges come from the synchronised pin; the far party gives 32 per slot
      rise = st.bclk_sync[1] && !st.bclk_prev;                                  // [RULE2]
      fall = !st.bclk_sync[1] && st.bclk_prev;
    end
    launch = st.clock_edge_select ? fall : rise;                                // [RULE4] [RULE5]

    fs_now     = st.master_select ? st.fs : st.fs_sync[1];
    slot_start = 1'b0;
    fifo_take  = 1'b0;
    if (launch) begin
      if (st.master_select) begin
        slot_start = (st.bit_cnt == 5'h1F);                                     // [RULE1]
        if (slot_start) begin
          // frame sync moves on the launch edge so the latch edge sees it settled
          next_st.fs = !st.fs;
        end
      end else begin
        slot_start = (st.fs_sync[1] != st.fs_last);
        next_st.fs = 1'b0;
      end
      next_st.fs_last = st.fs_sync[1];
      if (slot_start) begin
        next_st.bit_cnt  = 5'h0;
        next_st.shift    = fifo_valid ? {fifo_data, {(32-SW){1'b0}}} : 32'h0;
        fifo_take        = fifo_valid;
        next_st.underrun = !fifo_valid;
      end else begin
        next_st.bit_cnt = st.bit_cnt + 5'h1;                                    // [RULE1]
        next_st.shift   = {st.shift[30:0], 1'b0};
      end
    end
    if (!st.master_select) begin
      next_st.fs = 1'b0;
    end

    // frame period in system clocks, classified at each frame-sync rise
    next_st.fs_rise_prev = fs_now;
    if (fs_now && !st.fs_rise_prev) begin
      next_st.period = 10'h1;
      if (st.period >= `RAS_P96_LO && st.period <= `RAS_P96_HI) begin           // [RULE8]
        next_st.rate = RAS_RATE_96;
      end else if (st.period >= `RAS_P882_LO && st.period <= `RAS_P882_HI) begin // [RULE8]
        next_st.rate = RAS_RATE_882;
      end else if (st.period >= `RAS_P48_LO && st.period <= `RAS_P48_HI) begin
        next_st.rate = RAS_RATE_48;
      end else if (st.period >= `RAS_P441_LO && st.period <= `RAS_P441_HI) begin
        next_st.rate = RAS_RATE_441;
      end else if (st.period >= `RAS_P32_LO && st.period <= `RAS_P32_HI) begin
        next_st.rate = RAS_RATE_32;
      end else begin
        next_st.rate = RAS_RATE_NONE;
      end
    end else if (st.period != `RAS_PERIOD_MAX) begin
      next_st.period = st.period + 10'h1;
    end else begin
      // no frame sync for too long: report nothing rather than a stale rate
      next_st.rate = RAS_RATE_NONE;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st         <= '0;
      st.bit_cnt <= 5'h1F;
      st.rate    <= RAS_RATE_NONE;
    end else begin
      st <= next_st;
    end
  end
endmodule

/* sim/ras_serial_out_sva.sv */
// Purpose: checker for the serial audio output port
// Assumes: mode inputs change only while reset is low
// Notes:   slot length is counted in system clocks between frame-sync changes
`timescale 1ns/10ps
`include "ras_map.svh"
module ras_serial_out_sva
  import ras_pkg::*;
(
  input wire logic                  I_SYS_CLK,
  input wire logic                  I_RST_N,
  input wire logic                  I_MASTER_SELECT,
  input wire logic                  I_CLOCK_EDGE_SELECT,
  input wire logic                  I_FIXED_FORMAT_EN,
  input wire logic [`RAS_FMT_W-1:0] I_FORMAT,
  input wire logic                  O_BIT_CLK,
  input wire logic                  O_BIT_CLK_OE,
  input wire logic                  O_FRAME_SYNC,
  input wire logic                  O_FRAME_SYNC_OE,
  input wire logic                  O_SERIAL_AUDIO_OUT,
  input ras_pkg::ras_rate_e         O_OUTPUT_WORD_RATE
);
  logic       mst_eff;
  logic       fall_eff;
  logic       fs_q;
  logic       fs_seen;
  logic [7:0] fs_gap;
  assign mst_eff  = I_FIXED_FORMAT_EN ? !(I_FORMAT inside {4'h1, 4'h3, 4'h9}) : I_MASTER_SELECT;
  assign fall_eff = I_FIXED_FORMAT_EN ? (I_FORMAT inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7})
                                      : I_CLOCK_EDGE_SELECT;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  // ****
  // gap counter: the first change after reset has no defined spacing
  // ****
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fs_q    <= 1'b0;
      fs_seen <= 1'b0;
      fs_gap  <= 8'h00;
    end else begin
      fs_q <= O_FRAME_SYNC;
      if (O_FRAME_SYNC != fs_q) begin
        fs_seen <= 1'b1;
        fs_gap  <= 8'h00;
      end else if (fs_gap != 8'hFF) begin
        fs_gap <= fs_gap + 8'h01;
      end
    end
  end
  a_oe_mode: assert property ($past(I_RST_N) |-> O_BIT_CLK_OE == $past(mst_eff))
    else $error("pin direction differs from selected mode");
  a_oe_pair: assert property (O_FRAME_SYNC_OE == O_BIT_CLK_OE)
    else $error("frame sync and bit clock directions differ");
  a_slave_quiet: assert property (!O_BIT_CLK_OE && !$past(O_BIT_CLK_OE) |-> !O_BIT_CLK && !O_FRAME_SYNC)
    else $error("clock outputs active while slave");
  a_div_four: assert property (O_BIT_CLK_OE && $rose(O_BIT_CLK) |->
    ##1 O_BIT_CLK ##1 !O_BIT_CLK [*2] ##1 O_BIT_CLK)
    else $error("bit clock is not master clock over four");
  a_slot_len: assert property (O_BIT_CLK_OE && fs_seen && O_FRAME_SYNC != fs_q |-> fs_gap == 8'h7F)
    else $error("slot shorter than 32 bit clocks");
  a_slot_late: assert property (O_BIT_CLK_OE && fs_seen |-> fs_gap < 8'h80)
    else $error("slot longer than 32 bit clocks");
  a_data_edge: assert property (O_BIT_CLK_OE && $changed(O_SERIAL_AUDIO_OUT) |->
    ($past(fall_eff) ? $fell(O_BIT_CLK) : $rose(O_BIT_CLK)))
    else $error("serial data changed off the launch edge");
  a_sync_edge: assert property (O_BIT_CLK_OE && $changed(O_FRAME_SYNC) |->
    ($past(fall_eff) ? $fell(O_BIT_CLK) : $rose(O_BIT_CLK)))
    else $error("frame sync changed off the launch edge");
  a_rate_master: assert property (O_BIT_CLK_OE |-> O_OUTPUT_WORD_RATE == RAS_RATE_NONE)
    else $error("rate reported for master frames");
endmodule
bind ras_serial_out ras_serial_out_sva sva (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N),
  .I_MASTER_SELECT(I_MASTER_SELECT), .I_CLOCK_EDGE_SELECT(I_CLOCK_EDGE_SELECT),
  .I_FIXED_FORMAT_EN(I_FIXED_FORMAT_EN), .I_FORMAT(I_FORMAT), .O_BIT_CLK(O_BIT_CLK),
  .O_BIT_CLK_OE(O_BIT_CLK_OE), .O_FRAME_SYNC(O_FRAME_SYNC), .O_FRAME_SYNC_OE(O_FRAME_SYNC_OE),
  .O_SERIAL_AUDIO_OUT(O_SERIAL_AUDIO_OUT), .O_OUTPUT_WORD_RATE(O_OUTPUT_WORD_RATE));

/* sim/ras_dsp_model.sv */
// Purpose: far-side processor that clocks and captures serial samples
// Assumes: bit clock stands at 0 while disabled
// Notes:   every completed 32-bit slot is queued in got
`timescale 1ns/10ps
module ras_dsp_model (
  input  wire logic i_en,
  input  wire logic i_launch_fall,
  input  int        i_half_ns,
  input  wire logic i_dev_oe,
  input  wire logic i_dev_bclk,
  input  wire logic i_dev_fs,
  input  wire logic i_data,
  output logic      o_bclk = 1'b0,
  output logic      o_fs = 1'b0
);
  logic [31:0] got[$];
  logic [31:0] sh = 32'h0;
  logic        fs_last = 1'b0;
  int          n = 0;
  int          nl = 0;
  wire  logic  bw = i_dev_oe ? i_dev_bclk : o_bclk;
  wire  logic  fw = i_dev_oe ? i_dev_fs : o_fs;
  // released frame sync toggles so a stale level never looks valid
  always begin
    #(i_half_ns + 1);
    if (!i_en) begin
      o_bclk = 1'b0;
      o_fs = ~o_fs;
      nl = 0;
    end else begin
      o_bclk = ~o_bclk;
      if (o_bclk != i_launch_fall) begin
        if (nl == 0) o_fs = ~o_fs;
        nl = (nl + 1) % 32;
      end
    end
  end
  always @(bw) begin
    if (bw == i_launch_fall) begin
      sh = (fw != fs_last) ? {31'h0, i_data} : {sh[30:0], i_data};
      n = (fw != fs_last) ? 1 : n + 1;
      fs_last = fw;
      if (n == 32) got.push_back(sh);
    end
  end
endmodule

/* sim/testbench.sv */
// Purpose: self-checking bench for the serial audio output port
// Assumes: modes change only under reset
// Notes:   leading empty slots are skipped when words are compared
`timescale 1ns/10ps
`include "ras_map.svh"
module testbench;
  import ras_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mst = 1'b1;
  logic        edg = 1'b1;
  logic        fix = 1'b0;
  logic [3:0]  fmt = 4'h0;
  logic        vld = 1'b0;
  logic [23:0] dat = 24'h000000;
  logic        p_en = 1'b0;
  logic        lf = 1'b1;
  int          half = 800;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [23:0] exp_q[$];
  wire logic   rdy, bck, bck_oe, fs, fs_oe, sdo, und, p_bck, p_fs;
  ras_rate_e   rate;
  always #50 sys_clk = ~sys_clk;
  ras_serial_out uut (.I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_MASTER_SELECT(mst),
    .I_CLOCK_EDGE_SELECT(edg), .I_FIXED_FORMAT_EN(fix), .I_FORMAT(fmt), .I_SAMPLE_VALID(vld),
    .I_SAMPLE_DATA(dat), .O_SAMPLE_READY(rdy), .I_BIT_CLK(bck_oe ? bck : p_bck), .O_BIT_CLK(bck),
    .O_BIT_CLK_OE(bck_oe), .I_FRAME_SYNC(fs_oe ? fs : p_fs), .O_FRAME_SYNC(fs),
    .O_FRAME_SYNC_OE(fs_oe), .O_SERIAL_AUDIO_OUT(sdo), .O_UNDERRUN(und),
    .O_OUTPUT_WORD_RATE(rate));
  ras_dsp_model partner (.i_en(p_en), .i_launch_fall(lf), .i_half_ns(half), .i_dev_oe(bck_oe),
    .i_dev_bclk(bck), .i_dev_fs(fs), .i_data(sdo), .o_bclk(p_bck), .o_fs(p_fs));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic start(input logic m, e, x, input logic [3:0] f, input int h);
    @(negedge sys_clk);
    rst_n = 1'b0;
    p_en = 1'b0;
    {mst, edg, fix, fmt, half} = {m, e, x, f, h};
    lf = x ? (f inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7}) : e;
    exp_q.delete();
    repeat (5) @(negedge sys_clk);
    // the partner's capture state would otherwise carry over from the last run
    partner.got.delete();
    partner.fs_last = 1'b0;
    partner.n = 64;
    rst_n = 1'b1;
    p_en = !(x ? !(f inside {4'h1, 4'h3, 4'h9}) : m);
  endtask
  task automatic send(input int n, output int taken);
    taken = 0;
    for (int k = 0; k < n; k++) begin
      @(negedge sys_clk);
      vld = 1'b1;
      if (rdy === 1'b1) begin
        dat = 24'h9A5C00 | 24'(k);
        exp_q.push_back(dat);
        taken++;
      end
    end
    @(negedge sys_clk);
    vld = 1'b0;
  endtask
  task automatic drain;
    int i;
    int nz;
    for (int w = 0; w < 8000; w++) begin
      @(negedge sys_clk);
      nz = 0;
      foreach (partner.got[j]) if (partner.got[j] != 32'h0) nz++;
      if (nz >= exp_q.size() && und === 1'b1) break;
    end
    i = 0;
    while (i < partner.got.size() && partner.got[i] == 32'h0) i++;
    foreach (exp_q[k]) chk("slot_word", partner.got[i + k], {exp_q[k], 8'h00});
    chk("underrun", und, 1);
  endtask
  task automatic results;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard: the whole sequence needs about 20000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    int t;
    int hs[5] = '{81, 88, 162, 177, 244};
    ras_rate_e rs[5] = '{RAS_RATE_96, RAS_RATE_882, RAS_RATE_48, RAS_RATE_441, RAS_RATE_32};
    start(1'b1, 1'b1, 1'b0, 4'h0, 800);
    send(12, t);
    // buffer depth, plus its output register, plus the word loaded by the first slot
    chk("words_taken", t, `RAS_FIFO_DEPTH + 2);
    chk("ready_full", rdy, 0);
    drain();
    chk("rate_master", rate, RAS_RATE_NONE);
    start(1'b1, 1'b0, 1'b0, 4'h0, 800);
    send(2, t);
    drain();
    start(1'b0, 1'b1, 1'b0, 4'h0, 800);
    send(4, t);
    drain();
    for (int f = 0; f < 10; f++) begin
      start(f[0], ~f[1], 1'b1, 4'(f), 800);
      repeat (3) @(negedge sys_clk);
      chk("fixed_oe", bck_oe, !(f inside {1, 3, 9}));
      send(1, t);
      drain();
    end
    for (int k = 0; k < 5; k++) begin
      start(1'b0, 1'b1, 1'b0, 4'h0, hs[k]);
      repeat (2500) @(negedge sys_clk);
      chk("rate_code", rate, rs[k]);
    end
    results();
  end
endmodule
